/* logic/alarm_consts.svh */
// named offsets, field positions, masks and widths of the dual alarm monitor
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

// ==========================================================
// register byte offsets (word sits at the even address)
`define OFS_LIMIT1 6'h20
`define OFS_LIMIT2 6'h22
`define OFS_COUNT1 6'h24
`define OFS_COUNT2 6'h26
`define OFS_CTRL 6'h28

// ==========================================================
// reset values and implemented-bit masks
`define REG_RESET 16'h0000
`define LIMIT_MASK 16'hBFFF
`define COUNT_MASK 16'h00FF
`define CTRL_MASK 16'hFF07
`define UNMAPPED_READ 16'h0000

// ==========================================================
// field positions and widths
`define DIR_BIT 15
`define LIM_MSB 13
`define SAMPLE_W 14
`define WIDE_W 16
`define COUNT_W_MAX 8
`define NUM_LINES 2

// one bit per source code: set where the output is twos complement
`define SRC_SIGNED 8'hCC

`endif

/* logic/alarm_pkg.sv */
// types shared by the dual alarm monitor files
`include "alarm_consts.svh"

package alarm_pkg;

  // ==========================================================
  // monitored source codes
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_SUPPLY = 3'h1,
    SRC_X_ACC = 3'h2,
    SRC_Y_ACC = 3'h3,
    SRC_AUX = 3'h4,
    SRC_TEMP = 3'h5,
    SRC_X_TILT = 3'h6,
    SRC_Y_TILT = 3'h7
  } alarm_src_e;

  // ==========================================================
  // alarm control register layout, bit 15 first
  typedef struct packed {
    logic roc2;
    alarm_src_e src2;
    logic roc1;
    alarm_src_e src1;
    logic [4:0] spare;
    logic out_en;
    logic out_high;
    logic out_line;
  } alarm_ctrl_s;

  typedef logic [`SAMPLE_W-1:0] sample_t;

  // one set of instantaneous output samples
  typedef struct packed {
    sample_t y_tilt;
    sample_t x_tilt;
    sample_t temp;
    sample_t aux;
    sample_t y_acc;
    sample_t x_acc;
    sample_t supply;
  } sample_set_s;

  // a claim on a digital line by another control register
  typedef struct packed {
    logic claim;
    logic level;
  } pin_claim_s;

  typedef enum logic [1:0] {
    WIN_OFF = 2'h0,
    WIN_PRIME = 2'h1,
    WIN_RUN = 2'h3
  } window_state_e;

endpackage : alarm_pkg

/* logic/alarm_channel.sv */
// one alarm monitor: threshold or rate-of-change evaluation of one value
`timescale 1ns/1ns
`include "alarm_consts.svh"

module alarm_channel #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic valid_i,
  input wire logic signed [`WIDE_W-1:0] value_i,
  input wire logic signed [`WIDE_W-1:0] limit_i,
  input wire logic above_i,
  input wire logic roc_i,
  input wire logic enable_i,
  input wire logic [COUNT_W-1:0] count_i,
  input wire logic restart_i,
  output logic active_o
);

  localparam int PROD_W = `WIDE_W + COUNT_W + 1;

  if (COUNT_W < 1 || COUNT_W > `COUNT_W_MAX)
  begin : g_bad_width
    $error("alarm_channel: COUNT_W out of range");
  end

  alarm_pkg::window_state_e state_q, state_d;
  logic signed [`WIDE_W-1:0] base_q, base_d;
  logic [COUNT_W-1:0] cnt_q, cnt_d;
  logic active_q, active_d;
  logic [COUNT_W-1:0] span;
  logic signed [`WIDE_W:0] delta;
  logic signed [PROD_W-1:0] delta_wide;
  logic signed [PROD_W-1:0] lim_scaled;

  // ==========================================================
  // next state
  always_comb
  begin
    // a zero count behaves as a window of one sample
    span = (count_i == '0) ? COUNT_W'(1) : count_i;
    delta = {value_i[`WIDE_W-1], value_i} - {base_q[`WIDE_W-1], base_q};
    delta_wide = PROD_W'(delta);
    // average change against limit equals total change against limit*span,
    // which avoids a divider
    lim_scaled = PROD_W'(limit_i) * $signed({1'b0, span});
    state_d = state_q;
    base_d = base_q;
    cnt_d = cnt_q;
    active_d = active_q;
    if (!enable_i || restart_i)
    begin
      state_d = alarm_pkg::WIN_OFF;
      cnt_d = '0;
      active_d = 1'b0;
    end
    else if (!roc_i)
    begin
      state_d = alarm_pkg::WIN_OFF;
      if (valid_i)
      begin
        active_d = above_i ? (value_i > limit_i) : (value_i < limit_i);
      end
    end
    else
    begin
      unique case (state_q)
        alarm_pkg::WIN_OFF:
        begin
          state_d = alarm_pkg::WIN_PRIME;
          active_d = 1'b0;
        end
        alarm_pkg::WIN_PRIME:
        begin
          if (valid_i)
          begin
            base_d = value_i;
            cnt_d = '0;
            state_d = alarm_pkg::WIN_RUN;
          end
        end
        alarm_pkg::WIN_RUN:
        begin
          if (valid_i)
          begin
            if (cnt_q == COUNT_W'(span - 1'b1))
            begin
              active_d = above_i ? (delta_wide > lim_scaled)
                                 : (delta_wide < lim_scaled);
              base_d = value_i;
              cnt_d = '0;
            end
            else
            begin
              cnt_d = COUNT_W'(cnt_q + 1'b1);
            end
          end
        end
        default:
        begin
          state_d = alarm_pkg::WIN_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= alarm_pkg::WIN_OFF;
      base_q <= '0;
      cnt_q <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      active_q <= active_d;
    end
  end

  assign active_o = active_q;

endmodule : alarm_channel

/* logic/alarm_pin_driver.sv */
// drives the two digital lines by claim priority
`timescale 1ns/1ns
`include "alarm_consts.svh"

module alarm_pin_driver (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic alarm_any_i,
  input wire logic out_en_i,
  input wire logic out_high_i,
  input wire logic out_line_i,
  input wire alarm_pkg::pin_claim_s [`NUM_LINES-1:0] misc_claim_i,
  input wire alarm_pkg::pin_claim_s [`NUM_LINES-1:0] gpio_claim_i,
  output logic [`NUM_LINES-1:0] line_out_o,
  output logic [`NUM_LINES-1:0] line_oe_n_o
);

  for (genvar i = 0; i < `NUM_LINES; i++)
  begin : g_line
    logic out_q, out_d;
    logic oe_n_q, oe_n_d;

    always_comb
    begin
      out_d = 1'b0;
      oe_n_d = 1'b1;
      if (misc_claim_i[i].claim)
      begin
        out_d = misc_claim_i[i].level;
        oe_n_d = 1'b0;
      end
      else if (out_en_i && (out_line_i == 1'(i)))
      begin
        // either alarm drives it; no latching, follows the live state
        out_d = out_high_i ? alarm_any_i : !alarm_any_i;
        oe_n_d = 1'b0;
      end
      else if (gpio_claim_i[i].claim)
      begin
        out_d = gpio_claim_i[i].level;
        oe_n_d = 1'b0;
      end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        out_q <= 1'b0;
        oe_n_q <= 1'b1;
      end
      else
      begin
        out_q <= out_d;
        oe_n_q <= oe_n_d;
      end
    end

    assign line_out_o[i] = out_q;
    assign line_oe_n_o[i] = oe_n_q;
  end

endmodule : alarm_pin_driver

/* logic/dual_alarm_monitor.sv */
// dual alarm monitor: registers, source selection and two alarm channels
`timescale 1ns/1ns
`include "alarm_consts.svh"

module dual_alarm_monitor #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [1:0] reg_be_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire alarm_pkg::sample_set_s samples_i,
  input wire alarm_pkg::pin_claim_s [`NUM_LINES-1:0] misc_claim_i,
  input wire alarm_pkg::pin_claim_s [`NUM_LINES-1:0] gpio_claim_i,
  input wire logic [`NUM_LINES-1:0] line_in_i,
  output logic [`NUM_LINES-1:0] line_out_o,
  output logic [`NUM_LINES-1:0] line_oe_n_o,
  output logic [`NUM_LINES-1:0] line_level_o,
  output logic [1:0] alarm_active_o
);

  if (COUNT_W < 1 || COUNT_W > `COUNT_W_MAX)
  begin : g_bad_width
    $error("dual_alarm_monitor: COUNT_W out of range");
  end

  // ==========================================================
  // helpers
  // unimplemented bits are cleared on the way in, so they always read back as zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wr,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (be[0])
    begin
      res[7:0] = wr[7:0];
    end
    if (be[1])
    begin
      res[15:8] = wr[15:8];
    end
    merge = res & mask;
  endfunction : merge

  function automatic alarm_pkg::sample_t pick(input alarm_pkg::sample_set_s s,
                                              input alarm_pkg::alarm_src_e src);
    alarm_pkg::sample_t v;
    v = '0;
    unique case (src)
      alarm_pkg::SRC_OFF: v = '0;
      alarm_pkg::SRC_SUPPLY: v = s.supply;
      alarm_pkg::SRC_X_ACC: v = s.x_acc;
      alarm_pkg::SRC_Y_ACC: v = s.y_acc;
      alarm_pkg::SRC_AUX: v = s.aux;
      alarm_pkg::SRC_TEMP: v = s.temp;
      alarm_pkg::SRC_X_TILT: v = s.x_tilt;
      alarm_pkg::SRC_Y_TILT: v = s.y_tilt;
    endcase
    pick = v;
  endfunction : pick

  // sign or zero extension to the common compare width
  function automatic logic [15:0] widen(input logic [`SAMPLE_W-1:0] v, input logic sgn);
    widen = {{(`WIDE_W-`SAMPLE_W){sgn & v[`SAMPLE_W-1]}}, v};
  endfunction : widen

  // ==========================================================
  // register file
  logic [15:0] limit_q [2];
  logic [15:0] limit_d [2];
  logic [15:0] count_q [2];
  logic [15:0] count_d [2];
  alarm_pkg::alarm_ctrl_s ctrl_q, ctrl_d;
  logic [1:0] restart_q, restart_d;
  logic [15:0] rdata_q, rdata_d;
  logic [5:0] word_addr;

  always_comb
  begin
    // bit 0 is ignored and reg_be_i picks the byte lanes; both bytes of a word share one decode
    word_addr = {reg_addr_i[5:1], 1'b0};
    limit_d = limit_q;
    count_d = count_q;
    ctrl_d = ctrl_q;
    restart_d = 2'h0;
    rdata_d = rdata_q;
    if (reg_wr_i)
    begin
      unique case (word_addr)
        `OFS_LIMIT1:
        begin
          limit_d[0] = merge(limit_q[0], reg_wdata_i, reg_be_i, `LIMIT_MASK);
          restart_d[0] = 1'b1;
        end
        `OFS_LIMIT2:
        begin
          limit_d[1] = merge(limit_q[1], reg_wdata_i, reg_be_i, `LIMIT_MASK);
          restart_d[1] = 1'b1;
        end
        `OFS_COUNT1:
        begin
          count_d[0] = merge(count_q[0], reg_wdata_i, reg_be_i, `COUNT_MASK);
          restart_d[0] = 1'b1;
        end
        `OFS_COUNT2:
        begin
          count_d[1] = merge(count_q[1], reg_wdata_i, reg_be_i, `COUNT_MASK);
          restart_d[1] = 1'b1;
        end
        `OFS_CTRL:
        begin
          ctrl_d = merge(ctrl_q, reg_wdata_i, reg_be_i, `CTRL_MASK);
          // a new source or mode voids any window in progress on both alarms
          restart_d = 2'h3;
        end
        default:
        begin
          restart_d = 2'h0;
        end
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (word_addr)
        `OFS_LIMIT1: rdata_d = limit_q[0];
        `OFS_LIMIT2: rdata_d = limit_q[1];
        `OFS_COUNT1: rdata_d = count_q[0];
        `OFS_COUNT2: rdata_d = count_q[1];
        `OFS_CTRL: rdata_d = ctrl_q;
        default: rdata_d = `UNMAPPED_READ;
      endcase
    end
  end

  // contents survive only in the outer storage; reset gives the defaults
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      limit_q[0] <= `REG_RESET;
      limit_q[1] <= `REG_RESET;
      count_q[0] <= `REG_RESET;
      count_q[1] <= `REG_RESET;
      ctrl_q <= `REG_RESET;
      restart_q <= 2'h0;
      rdata_q <= `REG_RESET;
    end
    else
    begin
      limit_q <= limit_d;
      count_q <= count_d;
      ctrl_q <= ctrl_d;
      restart_q <= restart_d;
      rdata_q <= rdata_d;
    end
  end

  // read data stay put until the next read strobe
  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // per-alarm source selection and evaluation
  logic [1:0] active;
  logic sel_valid_q, sel_valid_d;
  // the valid pulse is delayed one cycle to line up with the captured value

  always_comb
  begin
    sel_valid_d = sample_valid_i;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sel_valid_q <= 1'b0;
    end
    else
    begin
      sel_valid_q <= sel_valid_d;
    end
  end

  // both channels read the same sample set, so one source may be watched twice
  for (genvar k = 0; k < 2; k++)
  begin : g_alarm
    alarm_pkg::alarm_src_e src;
    logic rate_of_change_compare;
    logic sgn;
    logic signed [15:0] lim;
    logic [7:0] sgn_map;
    logic [15:0] val_q, val_d;

    always_comb
    begin
      src = (k == 0) ? ctrl_q.src1 : ctrl_q.src2;
      rate_of_change_compare = (k == 0) ? ctrl_q.roc1 : ctrl_q.roc2;
      // each source code picks its own bit of the signedness map
      sgn_map = `SRC_SIGNED;
      sgn = sgn_map[src];
      lim = widen(limit_q[k][`LIM_MSB:0], sgn);
      // raw instantaneous sample, never the averaged register value
      val_d = val_q;
      if (sample_valid_i)
      begin
        val_d = widen(pick(samples_i, src), sgn);
      end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        val_q <= '0;
      end
      else
      begin
        val_q <= val_d;
      end
    end

    alarm_channel #(
      .COUNT_W(COUNT_W)
    ) u_channel (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .valid_i(sel_valid_q),
      .value_i(val_q),
      .limit_i(lim),
      .above_i(limit_q[k][`DIR_BIT]),
      .roc_i(rate_of_change_compare),
      .enable_i(src != alarm_pkg::SRC_OFF),
      // limitation: stored count bits above COUNT_W are ignored by the channel
      .count_i(count_q[k][COUNT_W-1:0]),
      .restart_i(restart_q[k]),
      .active_o(active[k])
    );
  end

  // separate flags let the host find the source after the line fires
  assign alarm_active_o = active;

  // ==========================================================
  // digital lines
  // pin levels are asynchronous: nothing but the second flop reads the first
  logic [`NUM_LINES-1:0] sync1_q, sync2_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= line_in_i;
      sync2_q <= sync1_q;
    end
  end

  assign line_level_o = sync2_q;

  // the pin follows the channel flags one cycle later, never latched
  alarm_pin_driver u_pins (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .alarm_any_i(|active),
    .out_en_i(ctrl_q.out_en),
    .out_high_i(ctrl_q.out_high),
    .out_line_i(ctrl_q.out_line),
    .misc_claim_i(misc_claim_i),
    .gpio_claim_i(gpio_claim_i),
    .line_out_o(line_out_o),
    .line_oe_n_o(line_oe_n_o)
  );

endmodule : dual_alarm_monitor

/* test/alarm_monitor_properties.sv */
// port-level checker of the dual alarm monitor, bound to its top module
`timescale 1ns/1ns
`include "alarm_consts.svh"

module alarm_monitor_properties #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [1:0] reg_be_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire alarm_pkg::sample_set_s samples_i,
  input wire alarm_pkg::pin_claim_s [`NUM_LINES-1:0] misc_claim_i,
  input wire alarm_pkg::pin_claim_s [`NUM_LINES-1:0] gpio_claim_i,
  input wire logic [`NUM_LINES-1:0] line_in_i,
  input wire logic [`NUM_LINES-1:0] line_out_o,
  input wire logic [`NUM_LINES-1:0] line_oe_n_o,
  input wire logic [`NUM_LINES-1:0] line_level_o,
  input wire logic [1:0] alarm_active_o
);
  // ==========================================================
  // settle counter: the line synchroniser needs a few edges after reset
  logic [2:0] up_q;
  logic [2:0] up_d;
  always_comb
  begin
    up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      up_q <= 3'h0;
    else
      up_q <= up_d;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // properties
  misc_wins_zero_a:
    assert property (misc_claim_i[0].claim [*2] |-> !line_oe_n_o[0] &&
      line_out_o[0] == $past(misc_claim_i[0].level)) else $error("line zero ignores misc claim");
  misc_wins_one_a:
    assert property (misc_claim_i[1].claim [*2] |-> !line_oe_n_o[1] &&
      line_out_o[1] == $past(misc_claim_i[1].level)) else $error("line one ignores misc claim");
  level_sync_a:
    assert property ((up_q == 3'h7 && $stable(line_in_i)) [*4] |-> line_level_o == line_in_i)
      else $error("line level does not follow input");
  unmapped_read_a:
    assert property (reg_rd_i && (reg_addr_i[5:1] < 5'h10 || reg_addr_i[5:1] > 5'h14)
      |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  limit_spare_a:
    assert property (reg_rd_i && reg_addr_i[5:2] == 4'h8 |=> reg_rdata_o[14] == 1'b0)
      else $error("limit bit 14 stored");
  count_spare_a:
    assert property (reg_rd_i && reg_addr_i[5:2] == 4'h9 |=> reg_rdata_o[15:8] == 8'h00)
      else $error("count upper byte stored");
  ctrl_spare_a:
    assert property (reg_rd_i && reg_addr_i[5:1] == 5'h14 |=> reg_rdata_o[7:3] == 5'h00)
      else $error("control spare bits stored");
  rdata_hold_a:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  ctrl_restart_a:
    assert property ((!sample_valid_i) [*3] ##0 (reg_wr_i && reg_addr_i[5:1] == 5'h14)
      ##1 !sample_valid_i |=> alarm_active_o == 2'b00) else $error("alarm kept over control write");
  sample_paced_a:
    assert property ($rose(alarm_active_o[0]) |-> $past(sample_valid_i, 2))
      else $error("alarm rose without a sample");

  both_alarms_c: cover property (alarm_active_o == 2'b11);
  line_driven_c: cover property (!line_oe_n_o[0] && !misc_claim_i[0].claim);
  misc_claim_c: cover property (misc_claim_i[1].claim && !line_oe_n_o[1]);
endmodule : alarm_monitor_properties

bind dual_alarm_monitor alarm_monitor_properties #(.COUNT_W(COUNT_W)) chk_u (.clk_sys_i,
  .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_be_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .sample_valid_i, .samples_i, .misc_claim_i, .gpio_claim_i, .line_in_i, .line_out_o,
  .line_oe_n_o, .line_level_o, .alarm_active_o);

/* test/host_line_model.sv */
// host side of the two digital lines: board pull-up and wire resolution
`timescale 1ns/1ns

module host_line_model (
  input wire logic [1:0] line_out_i,
  input wire logic [1:0] line_oe_n_i,
  output logic [1:0] line_in_o
);
  // ==========================================================
  // a released line floats to the pull-up, never to the last driven value
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      line_in_o[i] = line_oe_n_i[i] ? 1'b1 : line_out_i[i];
    end
  end
endmodule : host_line_model

/* test/tb_top.sv */
// self-checking bench of the dual alarm monitor
`timescale 1ns/1ns
`include "alarm_consts.svh"

module tb_top;
  logic clk_sys_i;
  logic nrst_i;
  logic [5:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic [1:0] reg_be_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic sample_valid_i;
  alarm_pkg::sample_set_s samples_i;
  alarm_pkg::pin_claim_s [1:0] misc_claim_i;
  alarm_pkg::pin_claim_s [1:0] gpio_claim_i;
  logic [1:0] line_in_i, line_out_o, line_oe_n_o, line_level_o, alarm_active_o;
  logic [15:0] rv, l1, l2;
  logic [13:0] val;
  logic [13:0] rvals [5] = '{14'h0, 14'h3, 14'h10, 14'h11, 14'h12};
  logic [15:0] msk [6] = '{`LIMIT_MASK, `LIMIT_MASK, `COUNT_MASK, `COUNT_MASK, `CTRL_MASK,
    `UNMAPPED_READ};
  bit e1;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  dual_alarm_monitor #(.COUNT_W(8)) dut_u (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
    .reg_be_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .samples_i,
    .misc_claim_i, .gpio_claim_i, .line_in_i, .line_out_o, .line_oe_n_o, .line_level_o,
    .alarm_active_o);
  host_line_model host_u (.line_out_i(line_out_o), .line_oe_n_i(line_oe_n_o),
    .line_in_o(line_in_i));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic step;
    @(posedge clk_sys_i);
    #10;
  endtask : step

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    step();
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step();
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    step();
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step();
    reg_rd_i = 1'b0;
    rv = reg_rdata_o;
  endtask : rd

  // new sample set; returns once the threshold answer has landed
  task automatic samp(input int src, input logic [13:0] v);
    step();
    samples_i = 98'({$urandom, $urandom, $urandom, $urandom});
    if (src > 0)
      samples_i[(src-1)*14 +: 14] = v;
    sample_valid_i = 1'b1;
    step();
    sample_valid_i = 1'b0;
    step();
  endtask : samp

  function automatic bit threshold_compare(input int src, input logic [13:0] v, input logic [15:0] l);
    int sv;
    int sl;
    sv = v;
    sl = l[13:0];
    if (src inside {2, 3, 6, 7})
    begin
      sv = $signed(v);
      sl = $signed(l[13:0]);
    end
    if (src == 0)
      return 1'b0;
    return l[15] ? (sv > sl) : (sv < sl);
  endfunction : threshold_compare

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  initial
  begin
    nrst_i = 1'b0;
    reg_addr_i = 6'h00;
    reg_wdata_i = 16'h0000;
    reg_be_i = 2'h3;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sample_valid_i = 1'b0;
    samples_i = '0;
    misc_claim_i = 4'h0;
    gpio_claim_i = 4'h0;
    void'($urandom(1));
    repeat (8) @(posedge clk_sys_i);
    #10;
    nrst_i = 1'b1;
    // ==========================================================
    // defaults, masks, odd-address alias, unmapped word
    for (int i = 0; i < 6; i++)
    begin
      rd(6'h20 + 6'(2 * i));
      check(rv, 16'h0000);
      l1 = 16'($urandom);
      wr(6'h20 + 6'(2 * i), l1);
      rd(6'h21 + 6'(2 * i));
      check(rv, l1 & msk[i]);
    end
    // byte lanes: only the enabled half of the word changes
    wr(6'h22, 16'h0000);
    reg_be_i = 2'h2;
    wr(6'h22, 16'hFFFF);
    reg_be_i = 2'h3;
    rd(6'h22);
    check(rv, 16'hFF00 & `LIMIT_MASK);
    $display("register test done");
    // ==========================================================
    // threshold on every source code, both alarms on the same source
    for (int s = 0; s < 8; s++)
    begin
      l1 = {1'b1, 15'($urandom)};
      l2 = {1'b0, 15'($urandom)};
      wr(6'h20, l1);
      wr(6'h22, l2);
      wr(6'h28, {1'b0, 3'(s), 1'b0, 3'(s), 8'h00});
      for (int k = 0; k < 6; k++)
      begin
        val = (k < 2) ? (k == 0 ? l1[13:0] : l2[13:0]) : 14'($urandom);
        samp(s, val);
        check({14'h0, alarm_active_o}, {14'h0, threshold_compare(s, val, l2), threshold_compare(s, val, l1)});
      end
    end
    $display("threshold test done");
    // ==========================================================
    // line select and polarity; line follows the alarm without latching
    wr(6'h20, 16'h8010);
    for (int m = 0; m < 4; m++)
    begin
      wr(6'h28, 16'h0204 | 16'(m));
      for (int a = 1; a >= 0; a--)
      begin
        samp(2, a ? 14'h0020 : 14'h0001);
        step();
        check({14'h0, alarm_active_o}, {15'h0, a[0]});
        check({14'h0, line_oe_n_o}, m[0] ? 16'h1 : 16'h2);
        check({15'h0, line_out_o[m % 2]}, {15'h0, a[0] ^ !m[1]});
      end
    end
    // alarm two alone drives the shared line, then claim priority
    wr(6'h22, 16'h8010);
    wr(6'h28, 16'h2006);
    samp(2, 14'h0020);
    step();
    check({14'h0, line_out_o}, {14'h0, 2'b01});
    misc_claim_i = 4'h2;
    gpio_claim_i = 4'hE;
    repeat (2) step();
    check({12'h0, line_oe_n_o, line_out_o}, 16'h0002);
    misc_claim_i = 4'h0;
    repeat (5) step();
    check({12'h0, line_level_o, line_out_o}, 16'h000F);
    gpio_claim_i = 4'h0;
    $display("line test done");
    // ==========================================================
    // rate of change over two-sample windows: delta against limit times count
    wr(6'h20, 16'h8003);
    wr(6'h24, 16'h0002);
    wr(6'h28, 16'h0A00);
    e1 = 1'b0;
    repeat (2) step();
    for (int k = 0; k < 5; k++)
    begin
      samp(2, rvals[k]);
      if (k > 0 && k % 2 == 0)
        e1 = (int'(rvals[k]) - int'(rvals[k-2])) > 3 * 2;
      check({14'h0, alarm_active_o}, {15'h0, e1});
    end
    // alarm two, below its limit, zero count acts as a one-sample window
    wr(6'h22, 16'h3FFE);
    wr(6'h26, 16'h0000);
    wr(6'h28, 16'hA000);
    repeat (2) step();
    e1 = 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      val = 14'($urandom % 32);
      samp(2, val);
      if (k > 0)
        e1 = (int'(val) - int'(l2)) < -2;
      l2 = 16'(val);
      check({14'h0, alarm_active_o}, {14'h0, e1, 1'b0});
    end
    $display("rate test done");
    print_verdict();
  end
endmodule : tb_top
